// >>> sim/icu_cfg_slave_tb_top.sv
// Self-checking bench for the serial configuration slave with update delay
`default_nettype none

module icu_cfg_slave_tb_top
    import icu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [CNT_W-1:0] SW  = 20'h258;  // Register 0 window, 600 cycles
    localparam logic [CNT_W-1:0] CFG = 20'h190;  // Other windows, 400 cycles
    logic            clk   = 1'b0;
    logic            rst_n = 1'b0;
    logic            strap = 1'b0;
    logic            scl;
    logic            sda_low;
    logic            sda_o;
    logic            sda_oe;
    logic            src;
    logic            sda;
    logic [7:0][7:0] applied;
    logic [7:0]      shadow [0:7];
    int              n_mismatch = 0;
    int              compares   = 0;
    int              cyc        = 0;

    // Open-drain wire with pull-up
    assign sda = !(sda_low || (sda_oe && !sda_o));

    icu_i2c_master u_icu_i2c_master (.i_clk_sys(clk), .i_sda(sda), .o_scl(scl),
                                     .o_sda_low(sda_low));
    icu_cfg_slave #(.SW_CYC(SW), .CFG_CYC(CFG)) u_icu_cfg_slave (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
        .o_sda_oe(sda_oe), .i_addr_lsb(strap), .o_cfg_applied(applied),
        .o_source_select_bit(src));

    // Clock
    always #5 clk = ~clk;

    // Cycle count and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Expected address byte and read value
    function automatic logic [7:0] ab(input logic rw);
        return {ADDR_HI, strap, rw};
    endfunction
    function automatic logic [7:0] exp_rd(input logic [7:0] p);
        return (p < 8) ? shadow[p[2:0]] : 8'h00;
    endfunction

    // Send a byte and check the acknowledge bit
    task automatic tx(input logic [7:0] b, input logic [7:0] ea);
        logic [7:0] r;
        logic       a;
        u_icu_i2c_master.xfer(b, 1'b1, r, a);
        chk("ack", ea, {7'h00, a});
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic fin);
        u_icu_i2c_master.start();
        tx(ab(1'b0), 8'h01);
        tx(p, 8'h01);
        tx(d, 8'h01);
        if (p < 8)
            shadow[p[2:0]] = d;
        if (fin)
            u_icu_i2c_master.stop();
    endtask

    task automatic rd(input logic [7:0] p, input logic newp);
        logic [7:0] r;
        logic       a;
        if (newp)
        begin
            u_icu_i2c_master.start();
            tx(ab(1'b0), 8'h01);
            tx(p, 8'h01);
        end
        u_icu_i2c_master.start();
        tx(ab(1'b1), 8'h01);
        u_icu_i2c_master.xfer(8'hFF, 1'b0, r, a);
        u_icu_i2c_master.stop();
        chk("read", exp_rd(p), r);
    endtask

    // Main sequence
    initial
    begin
        logic [7:0] d1;
        logic [7:0] g;
        int         t0;
        void'($urandom(32'h79e2));
        for (int i = 0; i < 8; i++)
            shadow[i] = REG_RST_VAL;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t0 = cyc;
        for (int i = 0; i < 8; i++)
            chk("applied", REG_RST_VAL, applied[i]);
        chk("source", 8'h00, {7'h00, src});
        repeat (3) @(negedge clk);
        wr(8'h00, 8'h01, 1'b1);
        chk("applied", 8'h00, applied[0]);
        wait (cyc >= t0 + int'(SW) - 10);
        @(negedge clk);
        chk("applied", 8'h00, applied[0]);
        chk("source", 8'h00, {7'h00, src});
        wait (cyc >= t0 + int'(SW) + 10);
        @(negedge clk);
        chk("applied", 8'h01, applied[0]);
        chk("source", 8'h01, {7'h00, src});
        $display("test reset_window done, mismatches %0d", n_mismatch);
        for (int s = 0; s < 2; s++)
        begin
            strap = s[0];
            g = 8'($urandom_range(1, 7));
            d1 = 8'($urandom);
            wr(g, d1, 1'b0);
            t0 = cyc;
            repeat (2) @(negedge clk);
            chk("applied", d1, applied[g[2:0]]);
            wr(g, ~d1, 1'b0);
            chk("applied", d1, applied[g[2:0]]);
            rd(g, 1'b0);
            wait (cyc >= t0 + int'(CFG) + 5);
            @(negedge clk);
            chk("applied", ~d1, applied[g[2:0]]);
            u_icu_i2c_master.start();
            tx({ADDR_HI ^ 6'(1 << $urandom_range(0, 5)), strap, 1'b0}, 8'h00);
            u_icu_i2c_master.start();
            tx({ADDR_HI, ~strap, 1'b0}, 8'h00);
            u_icu_i2c_master.stop();
        end
        $display("test delay_window done, mismatches %0d", n_mismatch);
        for (int k = 0; k < 6; k++)
        begin
            g = (k == 5) ? 8'hF0 : 8'($urandom_range(0, 7));
            wr(g, 8'($urandom), 1'b1);
            rd(g, 1'b1);
            rd(g, 1'b0);
        end
        $display("test readback done, mismatches %0d", n_mismatch);
        // Select source B, let every window run out, then reset in mid-run
        wr(8'h00, 8'h01, 1'b1);
        repeat (620) @(negedge clk);
        chk("source", 8'h01, {7'h00, src});
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            shadow[i] = REG_RST_VAL;
            chk("applied", REG_RST_VAL, applied[i]);
        end
        chk("source", 8'h00, {7'h00, src});
        repeat (3) @(negedge clk);
        wr(8'h00, 8'h01, 1'b1);
        chk("applied", 8'h00, applied[0]);
        rd(8'h00, 1'b1);
        rd(8'h03, 1'b1);
        $display("test mid_reset done, mismatches %0d", n_mismatch);
        close_out();
    end
endmodule

`default_nettype wire

// >>> sim/icu_i2c_master.sv
// Serial bus master model that drives the configuration slave in the bench
`default_nettype none

module icu_i2c_master (
    // Timing reference
    input  wire logic i_clk_sys,
    // Bus wires
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda_low
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idles released, clock standing high between frames
    initial
    begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    // Quarter of the 80 ns bus period
    task automatic q();
        repeat (2) @(negedge i_clk_sys);
    endtask

    // One bit: data moves while clock is low, sampled while high
    task automatic bit_x(input logic b, output logic r);
        o_sda_low = !b;
        q();
        o_scl = 1'b1;
        q();
        r = i_sda;
        q();
        o_scl = 1'b0;
        q();
    endtask

    // Start or repeated start: data falls while clock high
    task automatic start();
        o_sda_low = 1'b0;
        q();
        o_scl = 1'b1;
        q();
        o_sda_low = 1'b1;
        q();
        o_scl = 1'b0;
        q();
    endtask

    // Stop: data rises while clock high, then the bus is left released
    task automatic stop();
        o_sda_low = 1'b1;
        q();
        o_scl = 1'b1;
        q();
        o_sda_low = 1'b0;
        q();
    endtask

    // Eight bits MSB first, then the ninth (acknowledge) bit
    task automatic xfer(input logic [7:0] b, input logic nine, output logic [7:0] r,
                        output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(b[i], r[i]);
        end
        bit_x(nine, x);
        ack = !x;
    endtask
endmodule

`default_nettype wire

// >>> src/icu_cfg_slave.sv
// Serial configuration slave with per-register update delay windows
`default_nettype none

// What this block does
// - Reset pin low returns every configuration register to its default.
// - Reset clears the source select bit to A and starts its delay window.
// - Seven-bit address, MSB first: fixed 100100 plus strap pin as LSB.
// - Direction bit 0 after a matching address is acknowledged.
// - Eight-bit pointer is acknowledged and latched as target register.
// - Write data byte is stored at the pointer, then acknowledged.
// - After a write a stop or repeated start of any kind may follow.
// - Read: repeated start, same address with direction 1, acknowledged.
// - Read shifts out the pointed register, MSB first.
// - After a read a stop or repeated start of any kind may follow.
// - Update delay starts at the falling clock edge of last data bit.
// - Each register has its own update delay length.
// - Writes during a window are kept but not applied until it ends.
// - Writes during a window do not restart it; newer value wins.
// - At window end the latest written value is applied.
// - A write with no window open applies at once and opens one.
// - Source select 0 routes source A, 1 routes source B.
module icu_cfg_slave
    import icu_pkg::*;
#(
    parameter int                         NREG    = NUM_REGS,
    parameter logic [CNT_W-1:0]           SW_CYC  = CNT_W'(SW_DELAY_CYC),
    parameter logic [CNT_W-1:0]           CFG_CYC = CNT_W'(CFG_DELAY_CYC),
    parameter logic [NREG-1:0][CNT_W-1:0] UPD_CYC = {{(NREG-1){CFG_CYC}}, SW_CYC}
)(
    // Clock and reset
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rst_n,
    // Serial bus pins
    input  wire logic                 i_scl,
    input  wire logic                 i_sda,
    output var  logic                 o_sda_o,
    output var  logic                 o_sda_oe,
    // Address strap
    input  wire logic                 i_addr_lsb,
    // Applied physical state
    output var  logic [NREG-1:0][7:0] o_cfg_applied,
    output var  logic                 o_source_select_bit
);

    // ****************************************
    // Pin synchronisers and bus events
    // ****************************************
    logic [2:0]  sync1_r;
    logic [2:0]  sync2_r;
    logic        scl_d_r;
    logic        sda_d_r;
    icu_bus_ev_t ev;

    // Two stages for each pin; only stage two is read
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_r <= 3'h7;
            sync2_r <= 3'h7;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            sync1_r <= {i_addr_lsb, i_sda, i_scl};
            sync2_r <= sync1_r;
            scl_d_r <= sync2_r[0];
            sda_d_r <= sync2_r[1];
        end
    end

    // Edge and condition decode
    assign ev.rise  = sync2_r[0] & ~scl_d_r;
    assign ev.fall  = ~sync2_r[0] & scl_d_r;
    assign ev.start = sync2_r[0] & scl_d_r & ~sync2_r[1] & sda_d_r;
    assign ev.stop  = sync2_r[0] & scl_d_r & sync2_r[1] & ~sda_d_r;
    assign ev.sda   = sync2_r[1];

    // ****************************************
    // Protocol state machine
    // ****************************************
    icu_state_t state_r;
    icu_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic [7:0] tx_r;
    logic       rw_r;
    logic       sda_oe_r;
    // Written copies and window counters; the read path below reads the written copies
    logic [NREG-1:0][7:0]       cfg_wr_r;
    logic [NREG-1:0][CNT_W-1:0] upd_cnt_r;

    function automatic logic reg_hit(input logic [7:0] p);
        reg_hit = (32'(p) < NREG);
    endfunction

    wire       byte_done = ev.fall & (cnt_r == 4'(BIT_LAST));
    wire       addr_ok   = (shift_r[7:1] == {ADDR_HI, sync2_r[2]});
    wire [7:0] rd_val    = reg_hit(ptr_r) ? cfg_wr_r[ptr_r[2:0]] : 8'h00;
    icu_wr_t   wr;
    assign wr.go   = (state_r == ST_WDAT) & byte_done;
    assign wr.idx  = ptr_r;
    assign wr.data = shift_r;

    // Next state on bus events; start and stop override everything
    always_comb
    begin
        state_nxt = state_r;
        if (ev.start)
            state_nxt = ST_ADDR;
        else if (ev.stop)
            state_nxt = ST_IDLE;
        else if (ev.fall)
        begin
            unique case (state_r)
                ST_IDLE:  state_nxt = ST_IDLE;
                ST_ADDR:  state_nxt = byte_done ? (addr_ok ? ST_A_ACK : ST_IDLE) : ST_ADDR;
                ST_A_ACK: state_nxt = rw_r ? ST_RDAT : ST_PTR;
                ST_PTR:   state_nxt = byte_done ? ST_P_ACK : ST_PTR;
                ST_P_ACK: state_nxt = ST_WDAT;
                ST_WDAT:  state_nxt = byte_done ? ST_W_ACK : ST_WDAT;
                ST_W_ACK: state_nxt = ST_IDLE;
                ST_RDAT:  state_nxt = byte_done ? ST_R_ACK : ST_RDAT;
                ST_R_ACK: state_nxt = ST_IDLE;
                default:  state_nxt = ST_IDLE;
            endcase
        end
    end

    // Shift in on rising clock, count bits, move on falling clock
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= 4'h0;
            shift_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            if (ev.start || (ev.fall && state_nxt != state_r))
                cnt_r <= 4'h0;
            else if (ev.rise)
            begin
                cnt_r   <= cnt_r + 4'h1;
                shift_r <= {shift_r[6:0], ev.sda};
            end
        end
    end

    // Pointer, direction and read shifter
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ptr_r <= 8'h00;
            rw_r  <= 1'b0;
            tx_r  <= 8'h00;
        end
        else
        begin
            if (state_r == ST_ADDR && byte_done)
                rw_r <= shift_r[0];
            if (state_r == ST_PTR && byte_done)
                ptr_r <= shift_r;
            if (state_r == ST_A_ACK && ev.fall)
                tx_r <= {rd_val[6:0], 1'b0};
            else if (state_r == ST_RDAT && ev.fall)
                tx_r <= {tx_r[6:0], 1'b0};
        end
    end

    // Data line driver: acks and read bits, changed on falling clock, released at start and stop
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            sda_oe_r <= 1'b0;
        else if (ev.start || ev.stop)
            sda_oe_r <= 1'b0;
        else if (ev.fall)
        begin
            if (state_nxt == ST_A_ACK || state_nxt == ST_P_ACK || state_nxt == ST_W_ACK)
                sda_oe_r <= 1'b1;
            else if (state_r == ST_A_ACK && rw_r)
                sda_oe_r <= ~rd_val[7];
            else if (state_r == ST_RDAT && !byte_done)
                sda_oe_r <= ~tx_r[7];
            else
                sda_oe_r <= 1'b0;
        end
    end

    assign o_sda_oe = sda_oe_r;
    assign o_sda_o  = 1'b0;

    // ****************************************
    // Written values, windows and applied state
    // ****************************************
    // Per-register storage is declared with the protocol logic above

    for (genvar g = 0; g < NREG; g++)
    begin : g_reg
        wire hit = wr.go & reg_hit(wr.idx) & (wr.idx[2:0] == 3'(g));

        // Written copy and window counter per register
        always_ff @(posedge i_clk_sys or negedge i_rst_n)
        begin
            if (!i_rst_n)
            begin
                cfg_wr_r[g]      <= REG_RST_VAL;
                o_cfg_applied[g] <= REG_RST_VAL;
                upd_cnt_r[g]     <= (g == SRC_REG) ? UPD_CYC[g] : '0;
            end
            else
            begin
                if (hit)
                    cfg_wr_r[g] <= wr.data;
                if (upd_cnt_r[g] == '0)
                begin
                    if (hit)
                    begin
                        o_cfg_applied[g] <= wr.data;
                        upd_cnt_r[g]     <= UPD_CYC[g];
                    end
                end
                else
                begin
                    upd_cnt_r[g] <= upd_cnt_r[g] - 1'b1;
                    if (upd_cnt_r[g] == CNT_W'(1))
                        o_cfg_applied[g] <= hit ? wr.data : cfg_wr_r[g];
                end
            end
        end
    end

    // Routing select follows the applied source bit
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_source_select_bit <= 1'b0;
        else
            o_source_select_bit <= o_cfg_applied[SRC_REG][SRC_BIT];
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    wire wr0 = g_reg[SRC_REG].hit;

    // Address phase and acknowledges
    a_start_addr: assert property (ev.start |=> state_r == ST_ADDR)
        else $error("start did not enter address phase");
    a_addr_ack: assert property (state_r == ST_ADDR && byte_done && addr_ok |=> sda_oe_r)
        else $error("matching address not acknowledged");
    a_bad_addr: assert property (
        state_r == ST_ADDR && byte_done && !addr_ok |=> !sda_oe_r && state_r == ST_IDLE)
        else $error("foreign address acknowledged");
    a_dir_latch: assert property (
        state_r == ST_ADDR && byte_done |=> rw_r == $past(shift_r[0]))
        else $error("direction bit not latched");
    a_ptr_latch: assert property (
        state_r == ST_PTR && byte_done |=> ptr_r == $past(shift_r))
        else $error("pointer not latched");
    a_ptr_ack: assert property (
        state_r == ST_PTR && byte_done |=> sda_oe_r && state_r == ST_P_ACK)
        else $error("pointer not acknowledged");
    a_store_byte: assert property (
        wr0 |=> cfg_wr_r[SRC_REG] == $past(shift_r) && sda_oe_r)
        else $error("write byte not stored and acknowledged");
    a_drop_far: assert property (
        wr.go && !reg_hit(wr.idx) |=> $stable(cfg_wr_r))
        else $error("write beyond the register set was stored");
    a_ack_release: assert property (state_r == ST_W_ACK && ev.fall |=> !sda_oe_r)
        else $error("data line held after write acknowledge");

    // Bus conditions
    a_oe_release: assert property ((ev.start || ev.stop) |=> !sda_oe_r)
        else $error("data line held across start or stop");
    a_stop_idle: assert property (ev.stop |=> state_r == ST_IDLE)
        else $error("stop did not return to idle");

    // Read data path
    a_rd_turn: assert property (
        state_r == ST_A_ACK && ev.fall && rw_r |=> state_r == ST_RDAT)
        else $error("read address did not enter data phase");
    a_read_msb: assert property (
        state_r == ST_A_ACK && ev.fall && rw_r |=> sda_oe_r == ~$past(rd_val[7]))
        else $error("read msb wrong");
    a_rd_shift: assert property (
        state_r == ST_RDAT && ev.fall && !byte_done |=> sda_oe_r == ~$past(tx_r[7]))
        else $error("read bit out of order");
    a_rd_release: assert property (state_r == ST_RDAT && byte_done |=> !sda_oe_r)
        else $error("data line not released for master acknowledge");

    // Update windows
    a_wr_fall: assert property (wr.go |-> ev.fall && cnt_r == 4'(BIT_LAST))
        else $error("update not at last bit fall");
    a_win_hold: assert property (
        upd_cnt_r[SRC_REG] > CNT_W'(1) |=> $stable(o_cfg_applied[SRC_REG]))
        else $error("applied changed inside window");
    a_win_hold_cfg: assert property (
        upd_cnt_r[1] > CNT_W'(1) |=> $stable(o_cfg_applied[1]))
        else $error("applied changed inside a configuration window");
    a_win_count: assert property (
        upd_cnt_r[SRC_REG] != '0 |=> upd_cnt_r[SRC_REG] == $past(upd_cnt_r[SRC_REG]) - 1'b1)
        else $error("window counter did not count down");
    a_win_norestart: assert property (
        wr0 && upd_cnt_r[SRC_REG] != '0
        |=> upd_cnt_r[SRC_REG] == $past(upd_cnt_r[SRC_REG]) - 1'b1)
        else $error("window restarted by write");
    a_win_expire: assert property (
        upd_cnt_r[SRC_REG] == CNT_W'(1) && !wr0
        |=> o_cfg_applied[SRC_REG] == $past(cfg_wr_r[SRC_REG]))
        else $error("latest value not applied at window end");
    a_imm_apply: assert property (
        wr0 && upd_cnt_r[SRC_REG] == '0
        |=> o_cfg_applied[SRC_REG] == $past(shift_r)
            && upd_cnt_r[SRC_REG] == UPD_CYC[SRC_REG])
        else $error("idle write not applied at once");

    // Routing select lags the applied bit by one clock
    a_src_follow: assert property (
        1'b1 |=> o_source_select_bit == $past(o_cfg_applied[SRC_REG][SRC_BIT]))
        else $error("source select does not follow applied bit");

    // Main scenarios
    c_write: cover property (wr.go);
    c_read: cover property (state_r == ST_R_ACK && ev.rise && !ev.sda);
    c_win_end: cover property (upd_cnt_r[SRC_REG] == CNT_W'(1));
    c_late_write: cover property (wr0 && upd_cnt_r[SRC_REG] > CNT_W'(1));
    c_bad_addr: cover property (state_r == ST_ADDR && byte_done && !addr_ok);

endmodule

`default_nettype wire

// >>> src/icu_pkg.sv
// Shared constants and types for the serial configuration slave with update delay
`default_nettype none

package icu_pkg;

    // ****************************************
    // Clock and sizes
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int NUM_REGS      = 8;
    localparam int CNT_W         = 20;
    localparam int BIT_LAST      = 8;

    // ****************************************
    // Bus address and register layout
    // ****************************************
    localparam logic [5:0] ADDR_HI     = 6'h24;  // Fixed upper address bits 100100
    localparam int         SRC_REG     = 0;      // Register holding the source select bit
    localparam int         SRC_BIT     = 0;
    localparam logic [7:0] REG_RST_VAL = 8'h00;  // Default contents, source A

    // ****************************************
    // Update delay windows
    // ****************************************
    localparam int SW_DELAY_NS  = 200000;
    localparam int CFG_DELAY_NS = 20000;
    localparam int SW_DELAY_CYC  = (SW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CFG_DELAY_CYC = (CFG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_ADDR  = 9'h002,
        ST_A_ACK = 9'h004,
        ST_PTR   = 9'h008,
        ST_P_ACK = 9'h010,
        ST_WDAT  = 9'h020,
        ST_W_ACK = 9'h040,
        ST_RDAT  = 9'h080,
        ST_R_ACK = 9'h100
    } icu_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } icu_bus_ev_t;

    typedef struct packed {
        logic       go;
        logic [7:0] idx;
        logic [7:0] data;
    } icu_wr_t;

endpackage

`default_nettype wire
